/* src/loss_overlay_regs.vh */
// offsets, field positions and reset values of the loss pin overlay registers
// Functional notes
// - high-speed bit 0 lets high-speed signal loss drive the loss pin; resets 0.
// - high-speed bit 1 lets high-speed pll unlock drive the loss pin; resets 0.
// - high-speed bit 2 lets autozero-not-done drive the loss pin; resets 0.
// - high-speed bit 3 lets gain-control unlock drive the loss pin; resets 0.
// - high-speed bit 4 lets invalid code words drive the loss pin; resets 0.
// - high-speed bit 5 lets loss of block lock drive the loss pin; resets 0.
// - high-speed register resets to 0x0380, reserved bits 11:8 at 4'b0011.
// - low-speed bit 12 lets low-speed pll unlock drive the loss pin; resets 0.
// - low-speed bits 11:8 enable per-lane loss of sync onto the pin; reset 0.
// - low-speed bits 7:4 enable per-lane invalid code onto the pin; reset 0.
// - low-speed bits 3:0 enable per-lane signal loss onto the pin; reset 0.
// - lane signal loss exists only while low-speed loss detection is enabled.
`ifndef LOSS_OVERLAY_REGS_VH
`define LOSS_OVERLAY_REGS_VH

// -----------------------------------------------------------------------------
// register map
// -----------------------------------------------------------------------------
`define HS_OVERLAY_ADDR 16'h0009
`define LS_OVERLAY_ADDR 16'h000a
`define HS_OVERLAY_RESET 16'h0380
`define LS_OVERLAY_RESET 16'h4000

// -----------------------------------------------------------------------------
// high-speed overlay fields
// -----------------------------------------------------------------------------
`define HS_SIGNAL_LOSS_BIT 0
`define HS_PLL_UNLOCK_BIT 1
`define HS_AUTOZERO_BIT 2
`define HS_GAIN_UNLOCK_BIT 3
`define HS_BAD_CODEWORD_BIT 4
`define HS_BLOCK_UNLOCK_BIT 5

// -----------------------------------------------------------------------------
// low-speed overlay fields
// -----------------------------------------------------------------------------
`define LS_PLL_UNLOCK_BIT 12
`define LS_DESYNC_MSB 11
`define LS_DESYNC_LSB 8
`define LS_BAD_CODE_MSB 7
`define LS_BAD_CODE_LSB 4
`define LS_SIGNAL_LOSS_MSB 3
`define LS_SIGNAL_LOSS_LSB 0

`endif

/* src/status_sync.v */
// three-stage synchroniser for asynchronous fault levels
`timescale 1ns/100ps
module status_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;

    // -------------------------------------------------------------------------
    // capture chain; stage1 is read only by stage2
    // -------------------------------------------------------------------------
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a change is taken only when the last two stages agree, filtering glitches
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sync_out <= {WIDTH{1'b0}};
        else
        begin
            for (i = 0; i < WIDTH; i = i + 1)
            begin
                if (stage2[i] == stage3[i])
                    sync_out[i] <= stage3[i];
            end
        end
    end

endmodule

/* src/loss_pin_overlay_select.v */
// per-channel overlay registers and loss pin combining logic
`timescale 1ns/100ps
`include "loss_overlay_regs.vh"
module loss_pin_overlay_select (
    input wire clk,
    input wire rst_b,
    input wire [15:0] mgmt_addr,
    input wire mgmt_wr_en,
    input wire [15:0] mgmt_wdata,
    input wire mgmt_rd_en,
    output reg [15:0] mgmt_rdata,
    input wire base_loss,
    input wire hs_signal_loss,
    input wire hs_pll_unlock,
    input wire hs_autozero_pending,
    input wire hs_gain_unlock,
    input wire hs_bad_codeword,
    input wire hs_block_unlock,
    input wire ls_pll_unlock,
    input wire [3:0] ls_lane_desync,
    input wire [3:0] ls_lane_bad_code,
    input wire [3:0] ls_lane_signal_loss,
    input wire ls_signal_detect_enable,
    output reg channel_loss_pin
);

    reg [15:0] high_speed_loss_pin_overlay;
    reg [15:0] low_speed_loss_pin_overlay;
    reg next_loss;
    wire [20:0] raw_status;
    wire [20:0] sync_status;

    // -------------------------------------------------------------------------
    // status synchronisation
    // -------------------------------------------------------------------------
    // fault levels come from serdes clock domains, so all pass the sync chain
    assign raw_status = {ls_signal_detect_enable, base_loss, hs_signal_loss, hs_pll_unlock,
                         hs_autozero_pending, hs_gain_unlock, hs_bad_codeword, hs_block_unlock,
                         ls_pll_unlock, ls_lane_desync, ls_lane_bad_code, ls_lane_signal_loss};

    status_sync #(
        .WIDTH(21)
    ) u_status_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(raw_status),
        .sync_out(sync_status)
    );

    // unpacked in the same order as the concatenation above, lane n at bit n of each group
    wire s_detect_en = sync_status[20];
    wire s_base = sync_status[19];
    wire s_hs_los = sync_status[18];
    wire s_hs_pll = sync_status[17];
    wire s_hs_az = sync_status[16];
    wire s_hs_agc = sync_status[15];
    wire s_hs_code = sync_status[14];
    wire s_hs_block = sync_status[13];
    wire s_ls_pll = sync_status[12];
    wire [3:0] s_desync = sync_status[11:8];
    wire [3:0] s_bad_code = sync_status[7:4];
    wire [3:0] s_sig_loss = sync_status[3:0];

    // -------------------------------------------------------------------------
    // overlay registers
    // -------------------------------------------------------------------------
    // all bits writable, reserved fields included, so software can restore them
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            high_speed_loss_pin_overlay <= `HS_OVERLAY_RESET;
            low_speed_loss_pin_overlay <= `LS_OVERLAY_RESET;
        end
        else if (mgmt_wr_en)
        begin
            if (mgmt_addr == `HS_OVERLAY_ADDR)
                high_speed_loss_pin_overlay <= mgmt_wdata;
            if (mgmt_addr == `LS_OVERLAY_ADDR)
                low_speed_loss_pin_overlay <= mgmt_wdata;
        end
    end

    // registered read data; unmapped addresses read as zero
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mgmt_rdata <= 16'h0000;
        else if (mgmt_rd_en)
        begin
            case (mgmt_addr)
                `HS_OVERLAY_ADDR: mgmt_rdata <= high_speed_loss_pin_overlay;
                `LS_OVERLAY_ADDR: mgmt_rdata <= low_speed_loss_pin_overlay;
                default: mgmt_rdata <= 16'h0000;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // loss pin combining
    // -------------------------------------------------------------------------
    wire [3:0] lane_los_live = s_sig_loss & {4{s_detect_en}};

    always @*
    begin
        next_loss = s_base;
        next_loss = next_loss | (s_hs_los & high_speed_loss_pin_overlay[`HS_SIGNAL_LOSS_BIT]);
        next_loss = next_loss | (s_hs_pll & high_speed_loss_pin_overlay[`HS_PLL_UNLOCK_BIT]);
        next_loss = next_loss | (s_hs_az & high_speed_loss_pin_overlay[`HS_AUTOZERO_BIT]);
        next_loss = next_loss | (s_hs_agc & high_speed_loss_pin_overlay[`HS_GAIN_UNLOCK_BIT]);
        next_loss = next_loss | (s_hs_code & high_speed_loss_pin_overlay[`HS_BAD_CODEWORD_BIT]);
        next_loss = next_loss | (s_hs_block & high_speed_loss_pin_overlay[`HS_BLOCK_UNLOCK_BIT]);
        next_loss = next_loss | (s_ls_pll & low_speed_loss_pin_overlay[`LS_PLL_UNLOCK_BIT]);
        next_loss = next_loss |
            (|(s_desync & low_speed_loss_pin_overlay[`LS_DESYNC_MSB:`LS_DESYNC_LSB]));
        next_loss = next_loss |
            (|(s_bad_code & low_speed_loss_pin_overlay[`LS_BAD_CODE_MSB:`LS_BAD_CODE_LSB]));
        next_loss = next_loss |
            (|(lane_los_live & low_speed_loss_pin_overlay[`LS_SIGNAL_LOSS_MSB:`LS_SIGNAL_LOSS_LSB]));
    end

    // one flop stage only; the pin follows conditions without holding them
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            channel_loss_pin <= 1'b0;
        else
            channel_loss_pin <= next_loss;
    end

endmodule

/* tb/loss_pin_asserts.sv */
// assertions watching the loss pin overlay block ports
`timescale 1ns/100ps
module loss_pin_asserts (
    input wire clk,
    input wire rst_b,
    input wire [15:0] mgmt_addr,
    input wire mgmt_wr_en,
    input wire [15:0] mgmt_wdata,
    input wire mgmt_rd_en,
    input wire [15:0] mgmt_rdata,
    input wire base_loss,
    input wire hs_signal_loss,
    input wire hs_pll_unlock,
    input wire hs_autozero_pending,
    input wire hs_gain_unlock,
    input wire hs_bad_codeword,
    input wire hs_block_unlock,
    input wire ls_pll_unlock,
    input wire [3:0] ls_lane_desync,
    input wire [3:0] ls_lane_bad_code,
    input wire [3:0] ls_lane_signal_loss,
    input wire ls_signal_detect_enable,
    input wire channel_loss_pin
);
// -----------------------------------------------------------------------------
// helpers and checks
// -----------------------------------------------------------------------------
// every cause except lane signal loss, which the detect enable gates
wire other = base_loss | hs_signal_loss | hs_pll_unlock | hs_autozero_pending | hs_gain_unlock | hs_bad_codeword
    | hs_block_unlock | ls_pll_unlock | (|ls_lane_desync) | (|ls_lane_bad_code);
wire mapped = mgmt_addr == 16'h0009 || mgmt_addr == 16'h000a;
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
sequence wr_rd(a);
    mgmt_wr_en && mgmt_addr == a ##1 mgmt_rd_en && !mgmt_wr_en && mgmt_addr == a;
endsequence
// seven samples leave room for the filter and the output flop
base_pin_a:
    assert property (base_loss [*7] |-> channel_loss_pin) else $error("base loss missing on pin");
quiet_pin_a:
    assert property ((!other && !(|ls_lane_signal_loss)) [*7] |-> !channel_loss_pin) else $error("pin stuck high");
detect_mask_a:
    assert property ((!other && !ls_signal_detect_enable) [*7] |-> !channel_loss_pin) else $error("lane loss unmasked");
unmapped_read_a:
    assert property (mgmt_rd_en && !mapped |=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
rdata_hold_a:
    assert property (!mgmt_rd_en |=> $stable(mgmt_rdata)) else $error("read data moved");
hs_rw_a:
    assert property (wr_rd(16'h0009) |=> mgmt_rdata == $past(mgmt_wdata, 2)) else $error("hs readback wrong");
ls_rw_a:
    assert property (wr_rd(16'h000a) |=> mgmt_rdata == $past(mgmt_wdata, 2)) else $error("ls readback wrong");
reset_clear_a:
    assert property ($rose(rst_b) |-> !channel_loss_pin && mgmt_rdata == 16'h0000) else $error("reset state wrong");
endmodule
bind loss_pin_overlay_select loss_pin_asserts chk_u (.*);

/* tb/fault_board.sv */
// board-side fault sources feeding the overlay block
`timescale 1ns/100ps
module fault_board (
    input wire clk,
    input wire [18:0] req,
    output reg [18:0] lvl
);
// levels move on the edge, like a board flop, so they never glitch
initial lvl = 19'h00000;
always @(posedge clk)
begin
    lvl <= req;
end
endmodule

/* tb/tb.sv */
// self-checking bench for the loss pin overlay block
`timescale 1ns/100ps
module tb;
reg clk = 1'b0, rst_b = 1'b0, mgmt_wr_en = 1'b0, mgmt_rd_en = 1'b0, base_loss = 1'b0, ls_signal_detect_enable = 1'b1;
reg [15:0] mgmt_addr = 16'h0000, mgmt_wdata = 16'h0000, a, b;
reg [18:0] req = 19'h00000;
wire [18:0] lvl;
wire [15:0] mgmt_rdata;
wire channel_loss_pin;
integer err_count = 0, total_checks = 0, cycles = 0, i, p;
initial forever #50 clk = ~clk;
fault_board fb_u (.clk(clk), .req(req), .lvl(lvl));
loss_pin_overlay_select dut_u (.clk(clk), .rst_b(rst_b), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
    .mgmt_wdata(mgmt_wdata), .mgmt_rd_en(mgmt_rd_en), .mgmt_rdata(mgmt_rdata), .base_loss(base_loss),
    .hs_signal_loss(lvl[0]), .hs_pll_unlock(lvl[1]), .hs_autozero_pending(lvl[2]), .hs_gain_unlock(lvl[3]),
    .hs_bad_codeword(lvl[4]), .hs_block_unlock(lvl[5]), .ls_pll_unlock(lvl[6]), .ls_lane_desync(lvl[10:7]),
    .ls_lane_bad_code(lvl[14:11]), .ls_lane_signal_loss(lvl[18:15]),
    .ls_signal_detect_enable(ls_signal_detect_enable), .channel_loss_pin(channel_loss_pin));
task end_sim;
begin
    if (err_count == 0 && total_checks > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
end
endtask
task wr(input [15:0] ad, input [15:0] d);
begin
    mgmt_addr = ad;
    mgmt_wdata = d;
    mgmt_wr_en = 1'b1;
    @(posedge clk);
    #1 mgmt_wr_en = 1'b0;
end
endtask
task rd(input [15:0] ad, input [15:0] exp);
begin
    mgmt_addr = ad;
    mgmt_rd_en = 1'b1;
    @(posedge clk);
    #1 mgmt_rd_en = 1'b0;
    total_checks = total_checks + 1;
    if (mgmt_rdata !== exp)
    begin
        err_count = err_count + 1;
        $display("BAD rdata %h expected %h seen %h", ad, exp, mgmt_rdata);
    end
end
endtask
// pin judged only once the input filter and output flop have settled
task chk_pin(input exp);
begin
    repeat (8) @(posedge clk);
    #1 total_checks = total_checks + 1;
    if (channel_loss_pin !== exp)
    begin
        err_count = err_count + 1;
        $display("BAD channel_loss_pin expected %b seen %b", exp, channel_loss_pin);
    end
end
endtask
// one idle edge, so a strobe is never lowered and raised in one time step
task gap;
begin
    @(posedge clk);
    #1;
end
endtask
// ceiling far above the roughly 580 cycles the sequence needs
always @(posedge clk)
begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
        err_count = err_count + 1;
        end_sim;
    end
end
initial
begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(16'h0009, 16'h0380);
    gap;
    rd(16'h000a, 16'h4000);
    wr(16'h000b, 16'hffff);
    rd(16'h000b, 16'h0000);
    gap;
    rd(16'h0009, 16'h0380);
    // each enable against its own cause alone, so a swapped lane shows
    for (i = 0; i < 19; i = i + 1)
    begin
        a = (i < 6) ? 16'h0009 : 16'h000a;
        b = (i < 6) ? 16'h0380 : 16'h4000;
        p = (i < 6) ? i : (i == 6) ? 12 : (i < 11) ? i + 1 : (i < 15) ? i - 7 : i - 15;
        req = 19'h00001 << i;
        chk_pin(1'b0);
        wr(a, b | (16'h0001 << p));
        rd(a, b | (16'h0001 << p));
        chk_pin(1'b1);
        req = 19'h00000;
        chk_pin(1'b0);
        wr(a, b);
    end
    // lane 0 signal loss counts only while detection is on
    gap;
    wr(16'h000a, 16'h4001);
    ls_signal_detect_enable = 1'b0;
    req = 19'h08000;
    chk_pin(1'b0);
    ls_signal_detect_enable = 1'b1;
    chk_pin(1'b1);
    req = 19'h00000;
    base_loss = 1'b1;
    chk_pin(1'b1);
    base_loss = 1'b0;
    chk_pin(1'b0);
    // a reset in mid-run must bring both registers back to their defaults
    wr(16'h0009, 16'h003f);
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(16'h0009, 16'h0380);
    gap;
    rd(16'h000a, 16'h4000);
    chk_pin(1'b0);
    end_sim;
end
endmodule
